// File: include/memref_params.svh
`ifndef MEMREF_PARAMS_SVH
`define MEMREF_PARAMS_SVH
// Word layout, bit 11 is the most significant
`define WORD_W 12
`define OP_HI 11
`define OP_LO 9
`define ZERO_WORD 12'h000
`define ONE_WORD 12'h001
// Operation codes
`define OP_AND 3'h0
`define OP_TWOS_ADD 3'h1
`define OP_INCREMENT_SKIP_ZERO 3'h2
`define OP_DEPOSIT_CLEAR 3'h3
`define OP_SUBROUTINE_CALL 3'h4
`define OP_JUMP_DIRECT 3'h5
`define OP_LAST_MEMREF 3'h5
// Execution times in ns and the clock period
`define CLK_PERIOD_NS 100
`define LONG_TIME_NS 3000
`define SHORT_TIME_NS 1500
`define LONG_CYCLES ((`LONG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHORT_CYCLES ((`SHORT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Count value at which the wait state hands over to the done state
`define DONE_AT_CNT 6'h02
`endif

// File: include/memref_pkg.sv
package memref_pkg;
	// Decoded instruction handed to execution
	typedef struct packed {
		logic [2:0] opcode;
		logic memref;
		logic augmented;
	} decode_type;
	// Memory request toward core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [11:0] wdata;
	} mem_req_type;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_READ = 4'h2,
		ST_WAIT = 4'h4,
		ST_DONE = 4'h8
	} exec_state_type;
endpackage

// File: core/op_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "memref_params.svh"
module op_decode (
	input wire logic [`WORD_W-1:0] instr,
	output memref_pkg::decode_type dec
);
	import memref_pkg::*;
	// Opcode lives in the top three bits
	always_comb begin
		dec.opcode = instr[`OP_HI:`OP_LO]; // RQ2
		dec.memref = (dec.opcode <= `OP_LAST_MEMREF); // RQ3
		dec.augmented = ~dec.memref; // RQ4
	end
endmodule // op_decode
`default_nettype wire

// File: core/memref_instruction_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "memref_params.svh"
// Summary of operation
// RQ1 - Instructions and data are single twelve-bit words.
// RQ2 - Opcode comes from the three most significant instruction bits.
// RQ3 - Opcodes 0 to 5 access memory at the effective address; opcode 5 issues no read or write here.
// RQ4 - Opcodes 6 and 7 are flagged augmented and handed elsewhere.
// RQ5 - Opcode 0 ANDs memory into the work register, 3.0 us.
// RQ6 - Opcode 1 adds memory to work register, carry toggles link.
// RQ7 - Opcode 2 increments memory, writes back, skips when result is zero.
// RQ8 - Opcode 3 stores work register to memory then clears it.
// RQ9 - Opcode 4 stores return address, jumps to address plus one.
// RQ10 - Opcode 5 loads program counter with address, 1.5 us.
// RQ11 - Effective address arrives from outside; bit 11 is most significant.
module memref_instruction_exec (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [`WORD_W-1:0] instr,
	input wire logic [`WORD_W-1:0] eff_addr,
	input wire logic [`WORD_W-1:0] pc_in,
	input wire logic [`WORD_W-1:0] work_register_in,
	input wire logic link_in,
	input wire logic [`WORD_W-1:0] mem_rdata,
	output memref_pkg::mem_req_type mem_req,
	output logic [`WORD_W-1:0] work_register,
	output logic [`WORD_W-1:0] pc_out,
	output logic link,
	output logic done,
	output logic augmented,
	output logic busy
);
	import memref_pkg::*;

	// ****************************************
	// Decode
	// ****************************************
	decode_type dec;
	exec_state_type state_ff, nxt_state;
	logic [2:0] op_ff;
	logic [`WORD_W-1:0] addr_ff;
	logic [5:0] cnt_ff;
	logic [`WORD_W:0] sum;
	logic [`WORD_W-1:0] inc;
	logic [`WORD_W-1:0] data_ff;

	op_decode op_decode_i (
		.instr(instr),
		.dec(dec)
	);
	assign augmented = start & dec.augmented; // RQ4
	assign busy = (state_ff != ST_IDLE);
	assign sum = {1'b0, work_register} + {1'b0, data_ff}; // RQ6
	assign inc = data_ff + `ONE_WORD; // RQ7

	// ****************************************
	// Sequencer
	// ****************************************
	// One read cycle except for jump direct, then wait out the documented instruction time
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (start && dec.memref) begin
					nxt_state = (dec.opcode == `OP_JUMP_DIRECT) ? ST_WAIT : ST_READ;
				end
			end
			ST_READ: begin
				nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (cnt_ff <= `DONE_AT_CNT) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Cycle budget: total time covers start to done inclusive
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_ff <= 6'h00;
		end else if (state_ff == ST_IDLE && start && dec.memref) begin
			if (dec.opcode == `OP_JUMP_DIRECT) begin
				cnt_ff <= 6'(`SHORT_CYCLES - 1); // RQ10
			end else begin
				cnt_ff <= 6'(`LONG_CYCLES - 1); // RQ5
			end
		end else if (cnt_ff != 6'h00) begin
			cnt_ff <= cnt_ff - 6'h01;
		end
	end

	// Latch instruction fields; address comes from address formation
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			op_ff <= 3'h0;
			addr_ff <= `ZERO_WORD;
			data_ff <= `ZERO_WORD;
		end else if (state_ff == ST_IDLE && start) begin
			op_ff <= dec.opcode;
			addr_ff <= eff_addr; // RQ11
		end else if (state_ff == ST_READ) begin
			data_ff <= mem_rdata; // RQ1
		end
	end

	// ****************************************
	// Memory access
	// ****************************************
	// Read is issued at the start; write lands in the done cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mem_req <= '0;
		end else begin
			mem_req.rd <= (state_ff == ST_IDLE) && start && dec.memref &&
				(dec.opcode != `OP_JUMP_DIRECT); // RQ3
			mem_req.wr <= 1'b0;
			if (state_ff == ST_IDLE && start) begin
				mem_req.addr <= eff_addr;
			end
			if (nxt_state == ST_DONE && state_ff == ST_WAIT) begin
				case (op_ff)
					`OP_INCREMENT_SKIP_ZERO: begin
						mem_req.wr <= 1'b1;
						mem_req.wdata <= inc; // RQ7
					end
					`OP_DEPOSIT_CLEAR: begin
						mem_req.wr <= 1'b1;
						mem_req.wdata <= work_register; // RQ8
					end
					`OP_SUBROUTINE_CALL: begin
						mem_req.wr <= 1'b1;
						mem_req.wdata <= pc_out; // RQ9
					end
					default: begin
						mem_req.wr <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Architectural results
	// ****************************************
	// Registers are loaded from the caller at start, updated at completion
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			work_register <= `ZERO_WORD;
			pc_out <= `ZERO_WORD;
			link <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= (nxt_state == ST_DONE) && (state_ff == ST_WAIT);
			if (state_ff == ST_IDLE && start) begin
				work_register <= work_register_in;
				pc_out <= pc_in;
				link <= link_in;
			end else if (state_ff == ST_WAIT && nxt_state == ST_DONE) begin
				case (op_ff)
					`OP_AND: work_register <= work_register & data_ff; // RQ5
					`OP_TWOS_ADD: begin
						work_register <= sum[`WORD_W-1:0]; // RQ6
						link <= link ^ sum[`WORD_W]; // RQ6
					end
					`OP_INCREMENT_SKIP_ZERO: begin
						if (inc == `ZERO_WORD) begin
							pc_out <= pc_out + `ONE_WORD; // RQ7
						end
					end
					`OP_DEPOSIT_CLEAR: work_register <= `ZERO_WORD; // RQ8
					`OP_SUBROUTINE_CALL: pc_out <= addr_ff + `ONE_WORD; // RQ9
					`OP_JUMP_DIRECT: pc_out <= addr_ff; // RQ10
					default: pc_out <= pc_out;
				endcase
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Reads zero in the cycle after the taking edge, so the done cycle shows the budget minus two
	logic [5:0] run_cnt_ff;
	always_ff @(posedge clk) begin
		if (!rst_b || state_ff == ST_IDLE) begin
			run_cnt_ff <= 6'h00;
		end else begin
			run_cnt_ff <= run_cnt_ff + 6'h01;
		end
	end

	long_time_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff != `OP_JUMP_DIRECT |-> run_cnt_ff == 6'(`LONG_CYCLES - 2)) // RQ5
		else $error("memory op time wrong");
	short_time_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_JUMP_DIRECT |-> run_cnt_ff == 6'(`SHORT_CYCLES - 2)) // RQ10
		else $error("jump time wrong");
	aug_no_mem_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_ff == ST_IDLE && start && dec.augmented |=> !busy && !mem_req.rd) // RQ4
		else $error("augmented opcode started memory cycle");
	read_issue_a: assert property (@(posedge clk) disable iff (!rst_b)
		state_ff == ST_IDLE && start && dec.memref && dec.opcode != `OP_JUMP_DIRECT |=> mem_req.rd) // RQ3
		else $error("memory read missing");
	and_result_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_AND |-> work_register == ($past(work_register) & data_ff) && !mem_req.wr) // RQ5
		else $error("AND result wrong");
	add_link_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_TWOS_ADD |-> link == ($past(link) ^ $past(sum[`WORD_W]))) // RQ6
		else $error("link toggle wrong");
	isz_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_INCREMENT_SKIP_ZERO |-> mem_req.wr && mem_req.wdata == data_ff + `ONE_WORD) // RQ7
		else $error("increment write wrong");
	deposit_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_DEPOSIT_CLEAR |-> work_register == `ZERO_WORD && mem_req.wdata == $past(work_register)) // RQ8
		else $error("deposit clear wrong");
	call_target_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_SUBROUTINE_CALL |-> pc_out == addr_ff + `ONE_WORD && mem_req.wdata == $past(pc_out)) // RQ9
		else $error("call target wrong");
	jump_target_a: assert property (@(posedge clk) disable iff (!rst_b)
		done && op_ff == `OP_JUMP_DIRECT |-> pc_out == addr_ff && !mem_req.wr) // RQ10
		else $error("jump target wrong");

	add_seen_c: cover property (@(posedge clk) done && op_ff == `OP_TWOS_ADD && link != $past(link));
	skip_seen_c: cover property (@(posedge clk) done && op_ff == `OP_INCREMENT_SKIP_ZERO && mem_req.wdata == `ZERO_WORD);
	call_seen_c: cover property (@(posedge clk) done && op_ff == `OP_SUBROUTINE_CALL);
	jump_seen_c: cover property (@(posedge clk) done && op_ff == `OP_JUMP_DIRECT);
endmodule // memref_instruction_exec
`default_nettype wire

// File: verif/core_mem.sv
`timescale 1ns/1ns
`default_nettype none
module core_mem (
	input wire logic clk,
	input wire memref_pkg::mem_req_type mem_req,
	output logic [11:0] mem_rdata
);
	import memref_pkg::*;
	// ************
	// Storage
	// ************
	logic [11:0] mem [0:4095];
	logic rd_ff;
	logic [11:0] last_ff;
	// Writes land on the strobe edge, whole twelve-bit words only; plain always since the bench preloads words
	always @(posedge clk) begin
		rd_ff <= mem_req.rd;
		last_ff <= mem_rdata;
		if (mem_req.wr) begin
			mem[mem_req.addr] <= mem_req.wdata;
		end
	end
	// Data stands for the strobe cycle and the next; elsewhere it flips each cycle so stale data never looks valid
	always_comb begin
		mem_rdata = (mem_req.rd || rd_ff) ? mem[mem_req.addr] : ~last_ff;
	end
endmodule // core_mem
`default_nettype wire

// File: verif/tb_memref_instruction_exec.sv
`timescale 1ns/1ns
`default_nettype none
module tb_memref_instruction_exec;
	import memref_pkg::*;
	typedef struct packed {
		logic [2:0] op;
		logic [11:0] ac;
		logic lk;
		logic [11:0] mv, pc, ad, eac;
		logic elk;
		logic [11:0] epc, emv;
	} row_type;
	logic clk, rst_b, start, link_in, link, done, augmented, busy;
	logic [11:0] instr, eff_addr, pc_in, work_register_in, mem_rdata, work_register, pc_out;
	mem_req_type mem_req;
	row_type rows [8];
	int mismatches = 0;
	int cmp_count = 0;
	int n;
	memref_instruction_exec memref_instruction_exec_i (.clk(clk), .rst_b(rst_b), .start(start), .instr(instr),
		.eff_addr(eff_addr), .pc_in(pc_in), .work_register_in(work_register_in), .link_in(link_in),
		.mem_rdata(mem_rdata), .mem_req(mem_req), .work_register(work_register), .pc_out(pc_out), .link(link),
		.done(done), .augmented(augmented), .busy(busy));
	core_mem core_mem_i (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
	// ************
	// Helpers
	// ************
	task automatic chk_word(input string what, input logic [11:0] exp, input logic [11:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Entered at a falling edge; start stands for exactly one rising edge
	task automatic launch(input row_type r);
		instr = {r.op, 9'h0A5};
		eff_addr = r.ad;
		pc_in = r.pc;
		work_register_in = r.ac;
		link_in = r.lk;
		core_mem_i.mem[r.ad] = r.mv;
		start = 1'b1;
		#1 chk_bit("augmented", 1'b0, augmented);
		@(negedge clk);
		start = 1'b0;
	endtask
	// Counts rising edges from the taking edge until done is seen
	task automatic wait_done(output int cnt);
		cnt = 0;
		while (done !== 1'b1 && cnt < 60) begin
			@(negedge clk);
			cnt++;
		end
		if (done !== 1'b1) begin
			mismatches++;
			stop_test();
		end
	endtask
	// ************
	// Stimulus
	// ************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		start = 1'b0;
		instr = 12'h000;
		eff_addr = 12'h000;
		pc_in = 12'h000;
		work_register_in = 12'h000;
		link_in = 1'b0;
		rows = '{'{3'h0, 12'hF0F, 1'b0, 12'h3C3, 12'h101, 12'h020, 12'h303, 1'b0, 12'h101, 12'h3C3},
			'{3'h1, 12'hFFF, 1'b0, 12'h002, 12'h102, 12'h021, 12'h001, 1'b1, 12'h102, 12'h002},
			'{3'h1, 12'h123, 1'b1, 12'h111, 12'h103, 12'h022, 12'h234, 1'b1, 12'h103, 12'h111},
			'{3'h2, 12'h777, 1'b1, 12'h7FF, 12'h104, 12'h023, 12'h777, 1'b1, 12'h104, 12'h800},
			'{3'h2, 12'h777, 1'b0, 12'hFFF, 12'h105, 12'h024, 12'h777, 1'b0, 12'h106, 12'h000},
			'{3'h3, 12'hABC, 1'b1, 12'h5A5, 12'h106, 12'h025, 12'h000, 1'b1, 12'h106, 12'hABC},
			'{3'h4, 12'h321, 1'b0, 12'h000, 12'h215, 12'h300, 12'h321, 1'b0, 12'h301, 12'h215},
			'{3'h5, 12'h321, 1'b1, 12'h999, 12'h216, 12'h456, 12'h321, 1'b1, 12'h456, 12'h999}};
		repeat (2) @(negedge clk);
		chk_word("reset ac", 12'h000, work_register);
		chk_bit("reset busy", 1'b0, busy);
		rst_b = 1'b1;
		// Ordinary cases, one row each
		foreach (rows[i]) begin
			launch(rows[i]);
			wait_done(n);
			chk_word("cycles", (rows[i].op == 3'h5) ? 12'h00D : 12'h01C, 12'(n));
			chk_word("work register", rows[i].eac, work_register);
			chk_word("pc", rows[i].epc, pc_out);
			chk_bit("link", rows[i].elk, link);
			@(negedge clk);
			chk_bit("done pulse", 1'b0, done);
			chk_word("memory", rows[i].emv, core_mem_i.mem[rows[i].ad]);
		end
		// A second start while busy is ignored
		launch(rows[0]);
		repeat (3) @(negedge clk);
		instr = {3'h3, 9'h000};
		work_register_in = 12'h555;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		wait_done(n);
		chk_word("busy start cycles", 12'h01C, 12'(n + 4));
		chk_word("busy start ac", rows[0].eac, work_register);
		@(negedge clk);
		chk_word("busy start memory", rows[0].mv, core_mem_i.mem[rows[0].ad]);
		// Augmented codes raise the flag and start no run, though the start still loads the caller's registers
		for (int k = 6; k < 8; k++) begin
			instr = {3'(k), 9'h1FF};
			start = 1'b1;
			#1 chk_bit("augmented flag", 1'b1, augmented);
			@(negedge clk);
			start = 1'b0;
			#1 chk_bit("augmented busy", 1'b0, busy);
			chk_bit("augmented done", 1'b0, done);
			@(negedge clk);
		end
		// Reset in mid-run clears everything, then a fresh instruction works
		launch(rows[1]);
		repeat (5) @(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		chk_bit("mid reset busy", 1'b0, busy);
		chk_word("mid reset pc", 12'h000, pc_out);
		chk_bit("mid reset link", 1'b0, link);
		rst_b = 1'b1;
		launch(rows[5]);
		wait_done(n);
		chk_word("after reset ac", rows[5].eac, work_register);
		stop_test();
	end
endmodule // tb_memref_instruction_exec
`default_nettype wire
